// ### logic/hbx_defines.svh
// hbx_defines.svh: offsets, field positions, reset values and counts of the host bridge register block
// assumes: included by bare name from the package and the bridge module
`ifndef HBX_DEFINES_SVH
`define HBX_DEFINES_SVH

// register byte offsets on the register port
`define HBX_OFS_CFG_ADDR        8'h00
`define HBX_OFS_CFG_DATA        8'h04
`define HBX_OFS_BUS_RANGE       8'h08
`define HBX_OFS_SOFT_RESET      8'h0C
`define HBX_OFS_WIN_BASE        8'h10
`define HBX_REG_STRIDE          8'h04

// software reset key written to the reset register
`define HBX_SOFT_RESET_KEY      32'h0000_000A

// config address port fields, little-endian positions of big-endian bits
`define HBX_CA_REG_HI           31
`define HBX_CA_REG_LO           26
`define HBX_CA_DEV_HI           23
`define HBX_CA_DEV_LO           19
`define HBX_CA_FUN_HI           18
`define HBX_CA_FUN_LO           16
`define HBX_CA_BUS_HI           15
`define HBX_CA_BUS_LO           8
`define HBX_CA_EN_BIT           7
`define HBX_CA_WMASK            32'hFCFF_FF80

// bus number register fields
`define HBX_BN_PRI_HI           23
`define HBX_BN_PRI_LO           16
`define HBX_BN_SUB_HI           7
`define HBX_BN_SUB_LO           0
`define HBX_BN_WMASK            32'h00FF_00FF

`define HBX_RESET_WORD          32'h0000_0000

// translation windows
`define HBX_WINDOW_COUNT        4
`define HBX_TRANSLATION_REGS_OPTION 1'b1
`define HBX_WIN0_HIGH_BITS      16
`define HBX_WIN1_HIGH_BITS      19
`define HBX_WIN2_HIGH_BITS      7
`define HBX_WIN3_HIGH_BITS      25
// build-time high-order values, only used when the registers are left out
`define HBX_WIN0_BUILD_HIGH     32'h0000_0000
`define HBX_WIN1_BUILD_HIGH     32'h0000_0000
`define HBX_WIN2_BUILD_HIGH     32'h0000_0000
`define HBX_WIN3_BUILD_HIGH     32'h0000_0000

`endif

// ### logic/hbx_pkg.sv
// hbx_pkg.sv: types shared by the host bridge register block and its bench
// assumes: hbx_defines.svh on the include path
`include "hbx_defines.svh"

package hbx_pkg;

    typedef enum logic [0:0] {
        HBX_IDLE,
        HBX_CFG_WAIT
    } hbx_state_e;

    // one configuration cycle handed to the pci side
    typedef struct packed {
        logic        type1;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } hbx_cfg_cmd_s;

    // one register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        full_word;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } hbx_reg_req_s;

    typedef logic [1:0] hbx_win_t;

endpackage

// ### logic/hbx_bridge.sv
// hbx_bridge.sv: host bridge configuration mechanism, bus number range and address translation registers
// assumes: one outstanding register request at a time; the pci side answers a config cycle with i_cfg_done
//
// Function
// - software reset clears whole bridge only
// - address port latches writable bits, reads word
// - config ports accept full-word accesses only
// - byte swap between port and pci words
// - address port fields: register, device, function, bus
// - address port unused bits read zero
// - address port bit 24 enables config
// - data port access launches config cycle
// - cycle type from bus number compare
// - data port is 32-bit, reset zero
// - bus number register fields, reset zero
// - registers replace build-time high bits
// - one high-bits register per window
// - high-bits read: low bits zero
// - pci address: high bits plus low bits
// - 64 KiB window substitutes 16 bits
// - 128 byte window substitutes 25 bits
`timescale 1ns/100ps
`default_nettype none
`include "hbx_defines.svh"

module hbx_bridge (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst,
    // register port
    input  wire hbx_pkg::hbx_reg_req_s i_reg_req,
    output var  logic [31:0]           o_reg_rdata,
    output var  logic                  o_reg_ack,
    output var  logic                  o_reg_err,
    // configuration cycles toward pci
    output var  hbx_pkg::hbx_cfg_cmd_s o_cfg_cmd,
    output var  logic                  o_cfg_req,
    input  wire logic                  i_cfg_done,
    input  wire logic [31:0]           i_cfg_rdata,
    // address translation
    input  wire logic                  i_xl_valid,
    input  wire hbx_pkg::hbx_win_t     i_xl_win,
    input  wire logic [31:0]           i_xl_addr,
    output var  logic                  o_xl_valid,
    output var  logic [31:0]           o_xl_addr,
    // bridge reset status
    output var  logic                  o_soft_rst
);

    localparam int NWIN = `HBX_WINDOW_COUNT;

    // mask of the top n address bits of a window
    function automatic logic [31:0] high_mask(input hbx_pkg::hbx_win_t w);
        int n;
        n = 0;
        case (w)
            2'd0:    n = `HBX_WIN0_HIGH_BITS;
            2'd1:    n = `HBX_WIN1_HIGH_BITS;
            2'd2:    n = `HBX_WIN2_HIGH_BITS;
            default: n = `HBX_WIN3_HIGH_BITS;
        endcase
        high_mask = ~(32'hFFFF_FFFF >> n);
    endfunction

    function automatic logic [31:0] build_high(input hbx_pkg::hbx_win_t w);
        case (w)
            2'd0:    build_high = `HBX_WIN0_BUILD_HIGH;
            2'd1:    build_high = `HBX_WIN1_BUILD_HIGH;
            2'd2:    build_high = `HBX_WIN2_BUILD_HIGH;
            default: build_high = `HBX_WIN3_BUILD_HIGH;
        endcase
    endfunction

    // big-endian port word versus little-endian pci word
    function automatic logic [31:0] swap32(input logic [31:0] v);
        swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    logic                soft_rst_q;
    logic                rst_all;
    logic [31:0]         cfg_addr_q;
    logic [31:0]         cfg_data_q;
    logic [31:0]         bus_range_q;
    logic [31:0]         win_q [NWIN];
    hbx_pkg::hbx_state_e state_q;
    logic                pend_rd_q;

    // soft reset acts one cycle and spares everything outside the bridge
    assign rst_all = i_rst | soft_rst_q;

    logic        acc;
    logic        hit_addr;
    logic        hit_data;
    logic        hit_bus;
    logic        hit_rst;
    logic        hit_win;
    logic [1:0]  win_sel;
    logic [7:0]  tgt_bus;
    logic [7:0]  pri_bus;
    logic [7:0]  sub_bus;
    logic        is_type0;
    logic        is_type1;
    logic        cfg_ok;

    assign acc      = (i_reg_req.wr | i_reg_req.rd) & (state_q == hbx_pkg::HBX_IDLE);
    assign hit_addr = i_reg_req.addr == `HBX_OFS_CFG_ADDR;
    assign hit_data = i_reg_req.addr == `HBX_OFS_CFG_DATA;
    assign hit_bus  = i_reg_req.addr == `HBX_OFS_BUS_RANGE;
    assign hit_rst  = i_reg_req.addr == `HBX_OFS_SOFT_RESET;
    assign hit_win  = (i_reg_req.addr >= `HBX_OFS_WIN_BASE) && (i_reg_req.addr[1:0] == 2'b00)
                      && (i_reg_req.addr < `HBX_OFS_WIN_BASE + 8'(NWIN * 4));
    assign win_sel  = 2'((i_reg_req.addr - `HBX_OFS_WIN_BASE) >> 2);
    assign tgt_bus  = cfg_addr_q[`HBX_CA_BUS_HI:`HBX_CA_BUS_LO];
    assign pri_bus  = bus_range_q[`HBX_BN_PRI_HI:`HBX_BN_PRI_LO];
    assign sub_bus  = bus_range_q[`HBX_BN_SUB_HI:`HBX_BN_SUB_LO];
    assign is_type0 = tgt_bus == pri_bus;
    assign is_type1 = (tgt_bus > pri_bus) && (tgt_bus <= sub_bus);
    assign cfg_ok   = cfg_addr_q[`HBX_CA_EN_BIT] & (is_type0 | is_type1);

    // partial accesses to the config ports never reach pci
    logic cfg_port;
    logic bad_size;
    assign cfg_port = hit_addr | hit_data | hit_bus;
    assign bad_size = cfg_port & ~i_reg_req.full_word;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= acc & i_reg_req.wr & hit_rst & (i_reg_req.wdata == `HBX_SOFT_RESET_KEY);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            cfg_addr_q <= `HBX_RESET_WORD;
        end else if (acc & i_reg_req.wr & hit_addr & ~bad_size) begin
            cfg_addr_q <= i_reg_req.wdata & `HBX_CA_WMASK;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            bus_range_q <= `HBX_RESET_WORD;
        end else if (acc & i_reg_req.wr & hit_bus & ~bad_size) begin
            bus_range_q <= i_reg_req.wdata & `HBX_BN_WMASK;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            cfg_data_q <= `HBX_RESET_WORD;
        end else if (acc & i_reg_req.wr & hit_data & ~bad_size) begin
            cfg_data_q <= i_reg_req.wdata;
        end else if (state_q == hbx_pkg::HBX_CFG_WAIT && i_cfg_done && pend_rd_q) begin
            cfg_data_q <= swap32(i_cfg_rdata);
        end
    end

    // one high-bits register per window, only the window's top bits store
    genvar g;
    generate
        for (g = 0; g < NWIN; g++) begin : g_win
            always_ff @(posedge i_ref_clk) begin
                if (rst_all) begin
                    win_q[g] <= `HBX_RESET_WORD;
                end else if (acc & i_reg_req.wr & hit_win & (win_sel == 2'(g))) begin
                    win_q[g] <= i_reg_req.wdata & high_mask(2'(g));
                end
            end
        end
    endgenerate

    // config cycle sequencing
    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            state_q   <= hbx_pkg::HBX_IDLE;
            pend_rd_q <= 1'b0;
            o_cfg_req <= 1'b0;
            o_cfg_cmd <= '0;
        end else begin
            case (state_q)
                hbx_pkg::HBX_IDLE: begin
                    if (acc & hit_data & ~bad_size & cfg_ok) begin
                        state_q         <= hbx_pkg::HBX_CFG_WAIT;
                        pend_rd_q       <= i_reg_req.rd;
                        o_cfg_req       <= 1'b1;
                        o_cfg_cmd.type1 <= ~is_type0;
                        o_cfg_cmd.write <= i_reg_req.wr;
                        o_cfg_cmd.addr  <= {8'h00,
                                            is_type0 ? 8'h00 : tgt_bus,
                                            cfg_addr_q[`HBX_CA_DEV_HI:`HBX_CA_DEV_LO],
                                            cfg_addr_q[`HBX_CA_FUN_HI:`HBX_CA_FUN_LO],
                                            cfg_addr_q[`HBX_CA_REG_HI:`HBX_CA_REG_LO],
                                            1'b0, ~is_type0};
                        o_cfg_cmd.wdata <= swap32(i_reg_req.wdata);
                    end
                end
                hbx_pkg::HBX_CFG_WAIT: begin
                    if (i_cfg_done) begin
                        state_q   <= hbx_pkg::HBX_IDLE;
                        o_cfg_req <= 1'b0;
                    end
                end
                default: begin
                    state_q <= hbx_pkg::HBX_IDLE;
                end
            endcase
        end
    end

    // register answers; a launched data-port access answers when pci finishes
    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            o_reg_ack   <= 1'b0;
            o_reg_err   <= 1'b0;
            o_reg_rdata <= `HBX_RESET_WORD;
        end else begin
            o_reg_ack   <= 1'b0;
            o_reg_err   <= 1'b0;
            o_reg_rdata <= `HBX_RESET_WORD;
            if (state_q == hbx_pkg::HBX_CFG_WAIT && i_cfg_done) begin
                o_reg_ack   <= 1'b1;
                o_reg_rdata <= pend_rd_q ? swap32(i_cfg_rdata) : `HBX_RESET_WORD;
            end else if (acc & ~(hit_data & ~bad_size & cfg_ok)) begin
                o_reg_ack <= 1'b1;
                if (bad_size) begin
                    o_reg_err <= 1'b1;
                end else if (hit_addr) begin
                    o_reg_rdata <= cfg_addr_q & `HBX_CA_WMASK;
                end else if (hit_data) begin
                    o_reg_err   <= 1'b1;
                    o_reg_rdata <= cfg_data_q;
                end else if (hit_bus) begin
                    o_reg_rdata <= bus_range_q;
                end else if (hit_win) begin
                    o_reg_rdata <= win_q[win_sel] & high_mask(win_sel);
                end else if (!hit_rst) begin
                    o_reg_err <= 1'b1;
                end
            end
        end
    end

    // translation: high bits from the register, low bits straight through
    logic [31:0] xl_high;
    assign xl_high = `HBX_TRANSLATION_REGS_OPTION ? win_q[i_xl_win] : build_high(i_xl_win);

    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            o_xl_valid <= 1'b0;
            o_xl_addr  <= `HBX_RESET_WORD;
        end else begin
            o_xl_valid <= i_xl_valid;
            o_xl_addr  <= (xl_high & high_mask(i_xl_win)) | (i_xl_addr & ~high_mask(i_xl_win));
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_soft_rst <= 1'b0;
        end else begin
            o_soft_rst <= soft_rst_q;
        end
    end

endmodule

`default_nettype wire

// ### test/hbx_bridge_properties.sv
// port properties of the bridge register block
// assumes: bound to hbx_bridge, one register request outstanding
`timescale 1ns/100ps
`default_nettype none
`include "hbx_defines.svh"
module hbx_bridge_properties (
    // clock and reset
    input wire logic                  i_ref_clk,
    input wire logic                  i_rst,
    // register port
    input wire hbx_pkg::hbx_reg_req_s i_reg_req,
    input wire logic [31:0]           o_reg_rdata,
    input wire logic                  o_reg_ack,
    input wire logic                  o_reg_err,
    // config link, translation, reset status
    input wire hbx_pkg::hbx_cfg_cmd_s o_cfg_cmd,
    input wire logic                  o_cfg_req,
    input wire logic                  i_cfg_done,
    input wire logic [31:0]           i_cfg_rdata,
    input wire logic                  i_xl_valid,
    input wire hbx_pkg::hbx_win_t     i_xl_win,
    input wire logic [31:0]           i_xl_addr,
    input wire logic                  o_xl_valid,
    input wire logic [31:0]           o_xl_addr,
    input wire logic                  o_soft_rst
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // requests made while a config cycle pends are dropped
    wire tk = (i_reg_req.wr | i_reg_req.rd) & ~o_cfg_req;
    property p_err; o_reg_err |-> o_reg_ack; endproperty
    a_err: assert property (p_err) else $error("err without ack");
    property p_part; tk && !i_reg_req.full_word && i_reg_req.addr < 8'h0C
        |=> o_reg_ack && o_reg_err && !o_cfg_req; endproperty
    a_part: assert property (p_part) else $error("partial access not refused");
    property p_ca0; tk && i_reg_req.rd && i_reg_req.addr == 8'h00
        |=> (o_reg_rdata & ~`HBX_CA_WMASK) == 32'h0000_0000; endproperty
    a_ca0: assert property (p_ca0) else $error("address port fixed bits set");
    property p_go; tk && i_reg_req.full_word && i_reg_req.addr == 8'h04 |=> o_reg_ack || o_cfg_req; endproperty
    a_go: assert property (p_go) else $error("data port access ignored");
    property p_hold; o_cfg_req && !i_cfg_done |=> o_cfg_req && $stable(o_cfg_cmd); endproperty
    a_hold: assert property (p_hold) else $error("config cycle not held");
    property p_done; o_cfg_req && i_cfg_done |=> o_reg_ack && !o_cfg_req; endproperty
    a_done: assert property (p_done) else $error("config end not answered");
    property p_w0; i_xl_valid && i_xl_win == 2'd0
        |=> ((o_xl_addr ^ $past(i_xl_addr)) & 32'h0000_FFFF) == 32'h0000_0000; endproperty
    a_w0: assert property (p_w0) else $error("window 0 low bits changed");
    property p_w3; i_xl_valid && i_xl_win == 2'd3
        |=> o_xl_valid && ((o_xl_addr ^ $past(i_xl_addr)) & 32'h0000_007F) == 32'h0000_0000; endproperty
    a_w3: assert property (p_w3) else $error("window 3 low bits changed");
    property p_soft; tk && i_reg_req.wr && i_reg_req.addr == 8'h0C && i_reg_req.wdata == `HBX_SOFT_RESET_KEY
        |=> o_reg_ack ##[1:3] o_soft_rst; endproperty
    a_soft: assert property (p_soft) else $error("soft reset missing");
    c_cyc: cover property (o_cfg_req && i_cfg_done);
    c_t1: cover property (o_cfg_req && o_cfg_cmd.type1);
    c_sr: cover property (o_soft_rst);
endmodule
`default_nettype wire

// ### test/hbx_pci_target.sv
// config target standing on the far side of the bridge
// assumes: one config cycle at a time, request held until after done
`timescale 1ns/100ps
`default_nettype none
module hbx_pci_target (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // config link
    input  wire logic        i_cfg_req,
    input  wire logic [3:0]  i_wait,
    input  wire logic [31:0] i_data,
    output var  logic        o_cfg_done,
    output var  logic [31:0] o_cfg_rdata
);
    logic [3:0] cnt_q;
    logic       hit;
    assign hit = i_cfg_req && !o_cfg_done && cnt_q == i_wait;
    always_ff @(posedge i_ref_clk) begin
        cnt_q <= (i_rst || !i_cfg_req) ? 4'h0 : cnt_q + 4'h1;
        o_cfg_done <= !i_rst && hit;
        // outside the answer cycle the lines toggle, never a stale word
        o_cfg_rdata <= (hit || i_rst) ? i_data : ~o_cfg_rdata;
    end
endmodule
`default_nettype wire

// ### test/hbx_bridge_tb.sv
// self-checking bench of the bridge register block
// assumes: bridge, config target and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module hbx_bridge_tb;
    logic                  clk, rst, ack, er, creq, done, xv, ov, sr, sr_seen, seen;
    logic [3:0]            wt;
    logic [31:0]           rd, cr, pd, xa, oa;
    hbx_pkg::hbx_win_t     xw;
    hbx_pkg::hbx_reg_req_s req;
    hbx_pkg::hbx_cfg_cmd_s cmd, got;
    int                    err_count, checks;
    hbx_bridge hbx_bridge_i (.i_ref_clk(clk), .i_rst(rst), .i_reg_req(req), .o_reg_rdata(rd), .o_reg_ack(ack),
        .o_reg_err(er), .o_cfg_cmd(cmd), .o_cfg_req(creq), .i_cfg_done(done), .i_cfg_rdata(cr), .i_xl_valid(xv),
        .i_xl_win(xw), .i_xl_addr(xa), .o_xl_valid(ov), .o_xl_addr(oa), .o_soft_rst(sr));
    hbx_pci_target hbx_pci_target_i (.i_ref_clk(clk), .i_rst(rst), .i_cfg_req(creq), .i_wait(wt),
        .i_data(pd), .o_cfg_done(done), .o_cfg_rdata(cr));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (sr === 1'b1) sr_seen <= 1'b1;
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one register access: strobe for one edge, bounded wait for ack
    task automatic rop(input logic w, f, input logic [7:0] a, input logic [31:0] d, e, input logic ee);
        int n;
        n = 0;
        seen = 1'b0;
        @(negedge clk);
        req = '{w, !w, f, a, d};
        @(negedge clk);
        req.wr = 1'b0;
        req.rd = 1'b0;
        while (ack !== 1'b1 && n < 40) begin
            if (creq === 1'b1) got = cmd;
            seen = seen | (creq === 1'b1);
            @(negedge clk);
            n++;
        end
        if (n >= 40) err_count++;
        if (n >= 40) finish_test();
        if (!w) chk("rdata", e, rd);
        chk("err", {31'h0, ee}, {31'h0, er});
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++)
            if (i != 3) rop(1'b0, 1'b1, 8'(4 * i), 32'h0, 32'h0, 1'(i == 1));
        rop(1'b1, 1'b1, 8'h00, 32'hFFFF_FFFF, 32'h0, 1'b0);
        rop(1'b1, 1'b0, 8'h00, 32'h0, 32'h0, 1'b1);
        rop(1'b0, 1'b1, 8'h00, 32'h0, 32'hFCFF_FF80, 1'b0);
        rop(1'b1, 1'b1, 8'h08, 32'hFFFF_FFFF, 32'h0, 1'b0);
        rop(1'b0, 1'b1, 8'h08, 32'h0, 32'h00FF_00FF, 1'b0);
        $display("t_regs done");
    endtask
    task automatic t_cfg(input logic [3:0] lat);
        logic [7:0] b;
        logic       ok;
        logic       t1;
        wt = lat;
        rop(1'b1, 1'b1, 8'h08, 32'h0002_0005, 32'h0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            b = 8'(i + 1);
            ok = b >= 8'd2 && b <= 8'd5 && i != 3;
            t1 = b != 8'd2;
            rop(1'b1, 1'b1, 8'h00, {6'd9, 2'b00, 5'd21, 3'd6, b, 1'(i != 3), 7'h00}, 32'h0, 1'b0);
            if (i == 1) rop(1'b1, 1'b0, 8'h04, 32'h0, 32'h0, 1'b1);
            if (i == 1) chk("partial launch", 32'h0, {31'h0, seen});
            rop(1'b1, 1'b1, 8'h04, 32'h1122_3344, 32'h0, !ok);
            chk("launch", {31'h0, ok}, {31'h0, seen});
            if (ok) chk("cfg addr", {8'h00, t1 ? b : 8'h00, 5'd21, 3'd6, 6'd9, 1'b0, t1}, got.addr);
            if (ok) chk("cfg wdata", 32'h4433_2211, got.wdata);
            if (ok) chk("cfg dir", 32'h1, {31'h0, got.write});
            pd = 32'hA1B2_C3D4 + 32'(i);
            rop(1'b0, 1'b1, 8'h04, 32'h0, ok ? {pd[7:0], pd[15:8], pd[23:16], pd[31:24]} : 32'h1122_3344, !ok);
            if (ok) chk("cfg dir", 32'h0, {31'h0, got.write});
        end
        $display("t_cfg done");
    endtask
    task automatic t_xl();
        logic [31:0] mk [4] = '{32'hFFFF_0000, 32'hFFFF_E000, 32'hFE00_0000, 32'hFFFF_FF80};
        logic [31:0] hb [4] = '{32'h5671_0000, 32'hFEDC_0000, 32'h4000_0000, 32'h1234_5680};
        logic [31:0] la [4] = '{32'h1234_0ABC, 32'hABCD_F123, 32'hFFFE_DCBA, 32'h0000_004A};
        logic [31:0] pa [4] = '{32'h5671_0ABC, 32'hFEDC_1123, 32'h41FE_DCBA, 32'h1234_56CA};
        for (int i = 0; i < 4; i++) begin
            rop(1'b1, 1'b1, 8'(16 + 4 * i), 32'hFFFF_FFFF, 32'h0, 1'b0);
            rop(1'b0, 1'b1, 8'(16 + 4 * i), 32'h0, mk[i], 1'b0);
            rop(1'b1, 1'b1, 8'(16 + 4 * i), hb[i], 32'h0, 1'b0);
            xv = 1'b1;
            xw = 2'(i);
            xa = la[i];
            @(negedge clk);
            xv = 1'b0;
            chk("xl valid", 32'h1, {31'h0, ov});
            chk("xl addr", pa[i], oa);
        end
        $display("t_xl done");
    endtask
    task automatic t_soft();
        sr_seen = 1'b0;
        // a wrong key must leave the bridge alone
        rop(1'b1, 1'b1, 8'h0C, 32'h0000_0005, 32'h0, 1'b0);
        repeat (3) @(negedge clk);
        chk("no soft pulse", 32'h0, {31'h0, sr_seen});
        rop(1'b0, 1'b1, 8'h08, 32'h0, 32'h0002_0005, 1'b0);
        rop(1'b1, 1'b1, 8'h0C, 32'h0000_000A, 32'h0, 1'b0);
        repeat (3) @(negedge clk);
        chk("soft pulse", 32'h1, {31'h0, sr_seen});
        rop(1'b0, 1'b1, 8'h08, 32'h0, 32'h0, 1'b0);
        rop(1'b0, 1'b1, 8'h10, 32'h0, 32'h0, 1'b0);
        rop(1'b0, 1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
        rop(1'b0, 1'b1, 8'h04, 32'h0, 32'h0, 1'b1);
        rop(1'b0, 1'b1, 8'h20, 32'h0, 32'h0, 1'b1);
        $display("t_soft done");
    endtask
    initial begin
        err_count = 0;
        checks = 0;
        rst = 1'b1;
        req = '0;
        {xv, xw, xa, wt, pd, sr_seen} = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_cfg(4'd0);
        t_cfg(4'd7);
        t_xl();
        t_soft();
        finish_test();
    end
endmodule
bind hbx_bridge hbx_bridge_properties hbx_bridge_properties_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_reg_err(o_reg_err),
    .o_cfg_cmd(o_cfg_cmd), .o_cfg_req(o_cfg_req), .i_cfg_done(i_cfg_done), .i_cfg_rdata(i_cfg_rdata),
    .i_xl_valid(i_xl_valid), .i_xl_win(i_xl_win), .i_xl_addr(i_xl_addr), .o_xl_valid(o_xl_valid),
    .o_xl_addr(o_xl_addr), .o_soft_rst(o_soft_rst));
`default_nettype wire
